//--- hdl/uie_pkg.sv
package uie_pkg;

  // bus geometry
  localparam int          DATA_W = 32;
  localparam int          ADDR_W = 12;
  localparam int          STRB_W = DATA_W / 8;

  // register byte offsets
  localparam logic [11:0] OFF_INT_PENDING      = 12'h300;
  localparam logic [11:0] OFF_INT_ENABLE_SET   = 12'h304;
  localparam logic [11:0] OFF_INT_ENABLE_CLEAR = 12'h308;

  // field positions, shared by every register of the block
  localparam int          POS_FLOW_ASSERTED    = 0;
  localparam int          POS_FLOW_DEASSERTED  = 1;
  localparam int          POS_RX_BYTE_READY    = 2;
  localparam int          POS_TX_BYTE_SENT     = 7;
  localparam int          POS_RX_ERROR         = 9;
  localparam int          POS_RX_TIMEOUT       = 17;

  // reset values
  localparam logic [31:0] RST_WORD             = 32'h00000000;
  localparam logic        RST_FLOW_LEVEL_N     = 1'b1;

  // one bit per event, as carried inside the block
  typedef struct packed {
    logic receiver_timeout;
    logic rx_error;
    logic transmit_byte_sent;
    logic receive_byte_ready;
    logic flow_control_deasserted;
    logic flow_control_asserted;
  } uie_events_t;

  localparam int          EVENT_W = $bits(uie_events_t);

  // place the six event bits at their register positions
  function automatic logic [DATA_W-1:0] uie_to_word(input uie_events_t e);
    logic [DATA_W-1:0] w;
    w                      = RST_WORD;
    w[POS_FLOW_ASSERTED]   = e.flow_control_asserted;
    w[POS_FLOW_DEASSERTED] = e.flow_control_deasserted;
    w[POS_RX_BYTE_READY]   = e.receive_byte_ready;
    w[POS_TX_BYTE_SENT]    = e.transmit_byte_sent;
    w[POS_RX_ERROR]        = e.rx_error;
    w[POS_RX_TIMEOUT]      = e.receiver_timeout;
    return w;
  endfunction : uie_to_word

  // pick the six event bits out of a bus word
  function automatic uie_events_t uie_from_word(input logic [DATA_W-1:0] w);
    uie_events_t e;
    e.flow_control_asserted   = w[POS_FLOW_ASSERTED];
    e.flow_control_deasserted = w[POS_FLOW_DEASSERTED];
    e.receive_byte_ready      = w[POS_RX_BYTE_READY];
    e.transmit_byte_sent      = w[POS_TX_BYTE_SENT];
    e.rx_error                = w[POS_RX_ERROR];
    e.receiver_timeout        = w[POS_RX_TIMEOUT];
    return e;
  endfunction : uie_from_word

endpackage : uie_pkg

//--- hdl/uie_flow_edge.sv
// turns the active-low flow-control level into two one-cycle event pulses
module uie_flow_edge
  import uie_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic clear_to_send_n,
  output logic      asserted_pulse,
  output logic      deasserted_pulse
);

  logic level_reg;
  logic asserted_reg;
  logic deasserted_reg;
  logic asserted_next;
  logic deasserted_next;

  // a fall of the pin means the far end allows sending
  assign asserted_next   = level_reg & ~clear_to_send_n;
  assign deasserted_next = ~level_reg & clear_to_send_n;

  // idle level is high, so a pin held low at reset release gives one asserted event
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      level_reg      <= RST_FLOW_LEVEL_N;
      asserted_reg   <= 1'b0;
      deasserted_reg <= 1'b0;
    end else begin
      level_reg      <= clear_to_send_n;
      asserted_reg   <= asserted_next;
      deasserted_reg <= deasserted_next;
    end
  end

  assign asserted_pulse   = asserted_reg;
  assign deasserted_pulse = deasserted_reg;

endmodule : uie_flow_edge

//--- hdl/uie_top.sv
// Notes on behaviour
// - set-register flow asserted bit enables; reads state
// - set-register flow deasserted bit enables it
// - set-register receive ready bit enables it
// - set-register transmit sent bit enables it
// - set-register error bit enables it
// - set-register receiver timeout bit enables it
// - clear-register flow asserted bit disables; reads state
// - clear-register flow deasserted bit disables it
// - clear-register receive ready bit disables it
// - clear-register transmit sent bit disables it
// - clear-register error bit disables it
// - clear-register receiver timeout bit disables it
// - pin fall asserts, pin rise deasserts flow
module uie_top
  import uie_pkg::*;
#(
  parameter int AW = ADDR_W
)(
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [AW-1:0]         paddr,
  input  wire logic [DATA_W-1:0]     pwdata,
  input  wire logic [STRB_W-1:0]     pstrb,
  output logic      [DATA_W-1:0]     prdata,
  output logic                       pready,
  output logic                       pslverr,
  // flow-control pin and serial engine event pulses
  input  wire logic                  clear_to_send_n,
  input  wire logic                  receive_byte_ready,
  input  wire logic                  transmit_byte_sent,
  input  wire logic                  rx_error,
  input  wire logic                  receiver_timeout,
  // interrupt and visible state
  output logic                       irq,
  output uie_pkg::uie_events_t       int_enable
);

  import uie_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  uie_events_t       enable_reg;
  uie_events_t       enable_next;
  uie_events_t       pending_reg;
  uie_events_t       pending_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic              pready_reg;
  logic              pready_next;
  logic              pslverr_reg;
  logic              pslverr_next;
  logic              irq_reg;
  logic              irq_next;

  // ---------------------------------------------------------------
  // flow-control edges
  // ---------------------------------------------------------------
  logic flow_asserted_pulse;
  logic flow_deasserted_pulse;

  uie_flow_edge u_flow_edge (
    .core_clk         (core_clk),
    .rstn             (rstn),
    .clear_to_send_n  (clear_to_send_n),
    .asserted_pulse   (flow_asserted_pulse),
    .deasserted_pulse (flow_deasserted_pulse)
  );

  // all six events of this cycle in event order
  uie_events_t events_now;

  assign events_now.flow_control_asserted   = flow_asserted_pulse;
  assign events_now.flow_control_deasserted = flow_deasserted_pulse;
  assign events_now.receive_byte_ready      = receive_byte_ready;
  assign events_now.transmit_byte_sent      = transmit_byte_sent;
  assign events_now.rx_error                = rx_error;
  assign events_now.receiver_timeout        = receiver_timeout;

  // ---------------------------------------------------------------
  // apb phase tracking
  // ---------------------------------------------------------------
  logic setup_phase;
  logic access_done;
  logic write_done;
  logic read_done;

  // the slave answers in the first access cycle, so no wait states
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_reg;
  assign write_done  = access_done & pwrite;
  assign read_done   = access_done & ~pwrite;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] addr_low;
  logic              addr_aligned;
  logic              hit_pending;
  logic              hit_set;
  logic              hit_clear;
  logic              addr_mapped;

  // unused upper address bits must be zero, or the access is unmapped
  assign addr_low     = paddr[ADDR_W-1:0];
  // a shift rather than a part-select, so a bus of exactly ADDR_W bits still elaborates
  assign addr_aligned = (paddr[1:0] == 2'h0) && ((paddr >> ADDR_W) == '0);
  assign hit_pending  = addr_aligned && (addr_low == OFF_INT_PENDING);
  assign hit_set      = addr_aligned && (addr_low == OFF_INT_ENABLE_SET);
  assign hit_clear    = addr_aligned && (addr_low == OFF_INT_ENABLE_CLEAR);
  assign addr_mapped  = hit_pending | hit_set | hit_clear;

  // ---------------------------------------------------------------
  // write data, gated by byte strobes
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] lane_mask;
  logic [DATA_W-1:0] wr_bits;
  uie_events_t       set_bits;
  uie_events_t       clear_bits;

  // lanes without strobe write zeros, and zeros leave enables alone
  always_comb begin
    lane_mask = '0;
    for (int i = 0; i < STRB_W; i++) begin
      lane_mask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  assign wr_bits    = pwdata & lane_mask;
  assign set_bits   = (write_done && hit_set)   ? uie_from_word(wr_bits)
                                                : uie_events_t'('0);
  assign clear_bits = (write_done && hit_clear) ? uie_from_word(wr_bits)
                                                : uie_events_t'('0);

  // ---------------------------------------------------------------
  // enable state: one flop per event, shared by both registers
  // ---------------------------------------------------------------
  // ones in the set word turn enables on
  uie_events_t enable_after_set;

  assign enable_after_set.flow_control_asserted =
    enable_reg.flow_control_asserted | set_bits.flow_control_asserted;
  assign enable_after_set.flow_control_deasserted =
    enable_reg.flow_control_deasserted | set_bits.flow_control_deasserted;
  assign enable_after_set.receive_byte_ready =
    enable_reg.receive_byte_ready | set_bits.receive_byte_ready;
  assign enable_after_set.transmit_byte_sent =
    enable_reg.transmit_byte_sent | set_bits.transmit_byte_sent;
  assign enable_after_set.rx_error =
    enable_reg.rx_error | set_bits.rx_error;
  assign enable_after_set.receiver_timeout =
    enable_reg.receiver_timeout | set_bits.receiver_timeout;

  // ones in the clear word turn enables off; zeros keep the old value
  assign enable_next.flow_control_asserted =
    enable_after_set.flow_control_asserted & ~clear_bits.flow_control_asserted;
  assign enable_next.flow_control_deasserted =
    enable_after_set.flow_control_deasserted & ~clear_bits.flow_control_deasserted;
  assign enable_next.receive_byte_ready =
    enable_after_set.receive_byte_ready & ~clear_bits.receive_byte_ready;
  assign enable_next.transmit_byte_sent =
    enable_after_set.transmit_byte_sent & ~clear_bits.transmit_byte_sent;
  assign enable_next.rx_error =
    enable_after_set.rx_error & ~clear_bits.rx_error;
  assign enable_next.receiver_timeout =
    enable_after_set.receiver_timeout & ~clear_bits.receiver_timeout;

  // ---------------------------------------------------------------
  // sticky pending flags, cleared by reading them
  // ---------------------------------------------------------------
  uie_events_t read_clear;

  // only bits the reader actually saw are cleared, so a flag raised
  // between the setup edge and the completing edge is not lost
  assign read_clear   = (read_done && hit_pending) ? uie_from_word(prdata_reg)
                                                   : uie_events_t'('0);
  // a new event wins over a clear in the same cycle
  assign pending_next = uie_events_t'((pending_reg & ~read_clear) | events_now);

  // ---------------------------------------------------------------
  // read data and answer, captured in the setup cycle
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] enable_word;
  logic [DATA_W-1:0] pending_word;
  logic [DATA_W-1:0] read_sel;

  // both enable registers return the same shared state
  assign enable_word  = uie_to_word(enable_reg);
  assign pending_word = uie_to_word(pending_reg);
  assign read_sel     = hit_pending             ? pending_word :
                        (hit_set || hit_clear)  ? enable_word  :
                                                  RST_WORD;

  assign prdata_next  = setup_phase ? read_sel : prdata_reg;
  assign pready_next  = setup_phase;
  assign pslverr_next = setup_phase & ~addr_mapped;

  // interrupt follows the flags and enables of the coming cycle
  assign irq_next = |(pending_next & enable_next);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // enables and flags
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      enable_reg  <= uie_events_t'('0);
      pending_reg <= uie_events_t'('0);
      irq_reg     <= 1'b0;
    end else begin
      enable_reg  <= enable_next;
      pending_reg <= pending_next;
      irq_reg     <= irq_next;
    end
  end

  // bus answer
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prdata_reg  <= RST_WORD;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign irq        = irq_reg;
  assign int_enable = enable_reg;

endmodule : uie_top

//--- dv/uie_top_asserts.sv
// watches the enable registers, the apb answer and the interrupt level
module uie_top_asserts
  import uie_pkg::*;
#(
  parameter int AW = ADDR_W
)(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [AW-1:0]     paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [STRB_W-1:0] pstrb,
  input  wire logic [DATA_W-1:0] prdata,
  input  wire logic              pready,
  input  wire logic              pslverr,
  input  wire logic              clear_to_send_n,
  input  wire logic              receive_byte_ready,
  input  wire logic              transmit_byte_sent,
  input  wire logic              rx_error,
  input  wire logic              receiver_timeout,
  input  wire logic              irq,
  input  wire uie_events_t       int_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // bus words folded to event order, so no design function is reused
  wire logic        commit = psel && penable && pready;
  wire logic        wr_ok  = commit && pwrite && !pslverr && pstrb == 4'hF;
  wire uie_events_t w_ev   = {pwdata[17], pwdata[9], pwdata[7], pwdata[2], pwdata[1], pwdata[0]};
  wire uie_events_t r_ev   = {prdata[17], prdata[9], prdata[7], prdata[2], prdata[1], prdata[0]};
  wire uie_events_t in_ev  = {receiver_timeout, rx_error, transmit_byte_sent,
                              receive_byte_ready, 2'b00};

  reset_clear_a: assert property ($rose(rstn) |-> int_enable == '0 && !irq && !pready)
    else $error("enables or irq not zero after reset");
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer in the first access cycle");
  set_write_a: assert property (wr_ok && paddr == OFF_INT_ENABLE_SET |=>
    int_enable == ($past(int_enable) | $past(w_ev))) else $error("set write wrong");
  clear_write_a: assert property (wr_ok && paddr == OFF_INT_ENABLE_CLEAR |=>
    int_enable == ($past(int_enable) & ~$past(w_ev))) else $error("clear write wrong");
  hold_enable_a: assert property (!(commit && pwrite) |=> $stable(int_enable))
    else $error("enables moved without a write");
  read_enable_a: assert property (pready && !pwrite && !pslverr &&
    paddr != OFF_INT_PENDING |-> r_ev == int_enable && (prdata & ~32'h00020287) == '0)
    else $error("read of enables wrong");
  irq_enable_a: assert property (irq |-> int_enable != '0)
    else $error("irq with nothing enabled");
  event_irq_a: assert property ((in_ev & int_enable) != '0 &&
    !(commit && pwrite) |=> irq) else $error("enabled event gave no irq");
  flow_fall_a: assert property ($fell(clear_to_send_n) &&
    int_enable.flow_control_asserted |-> ##[1:3] irq) else $error("pin fall gave no irq");
  flow_rise_a: assert property ($rose(clear_to_send_n) &&
    int_enable.flow_control_deasserted |-> ##[1:3] irq) else $error("pin rise gave no irq");

  cover property (wr_ok && paddr == OFF_INT_ENABLE_CLEAR);
  cover property (irq);
  cover property (commit && pslverr);
endmodule : uie_top_asserts

bind uie_top uie_top_asserts #(.AW(AW)) u_asserts (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .clear_to_send_n(clear_to_send_n), .receive_byte_ready(receive_byte_ready),
  .transmit_byte_sent(transmit_byte_sent), .rx_error(rx_error),
  .receiver_timeout(receiver_timeout), .irq(irq), .int_enable(int_enable)
);

//--- dv/uie_top_bench.sv
module uie_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import uie_pkg::*;

  logic              core_clk = 1'b0;
  logic              rstn     = 1'b0;
  logic              psel     = 1'b0;
  logic              penable  = 1'b0;
  logic              pwrite   = 1'b0;
  logic [11:0]       paddr    = '0;
  logic [31:0]       pwdata   = '0;
  logic              cts_n    = 1'b1;
  logic [3:0]        ev       = '0;
  logic [3:0]        strb     = 4'hF;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  uie_events_t       int_enable;
  logic [31:0]       rd;
  logic              err;
  logic [31:0]       exp_en;
  int                miscompares = 0;
  int                compares    = 0;
  int                pos [6] = '{POS_FLOW_ASSERTED, POS_FLOW_DEASSERTED, POS_RX_BYTE_READY,
                                 POS_TX_BYTE_SENT, POS_RX_ERROR, POS_RX_TIMEOUT};

  // 50 MHz core clock
  always #10 core_clk = ~core_clk;

  // byte lanes stay on except in the one lane-mask test
  uie_top u_dut (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clear_to_send_n(cts_n), .receive_byte_ready(ev[0]),
    .transmit_byte_sent(ev[1]), .rx_error(ev[2]), .receiver_timeout(ev[3]),
    .irq(irq), .int_enable(int_enable)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one transfer; the idle edge first keeps psel from being driven twice at one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no limit here: the watchdog ends a hang
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // the answer is due in the first access cycle, with no wait state
    check("access cycles", n, 32'h1);
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rd_chk

  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge core_clk);
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask : irq_chk

  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // cuts a hang short; the tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    rd_chk(OFF_INT_ENABLE_SET, 32'h0, "set after reset");
    rd_chk(OFF_INT_ENABLE_CLEAR, 32'h0, "clear after reset");
    irq_chk(1'b0);
    $display("test reset done");
    exp_en = '0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFF_INT_ENABLE_SET, 32'h1 << pos[i]);
      apb(1'b1, OFF_INT_ENABLE_SET, 32'h0);
      exp_en |= 32'h1 << pos[i];
      rd_chk(OFF_INT_ENABLE_SET, exp_en, "set view");
      rd_chk(OFF_INT_ENABLE_CLEAR, exp_en, "clear view");
    end
    $display("test set done");
    // one-cycle pulse per event input, irq until the pending read
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      ev <= 4'h1 << k;
      @(posedge core_clk);
      ev <= 4'h0;
      irq_chk(1'b1);
      rd_chk(OFF_INT_PENDING, 32'h1 << pos[k+2], "pending");
      irq_chk(1'b0);
    end
    cts_n <= 1'b0;
    irq_chk(1'b1);
    rd_chk(OFF_INT_PENDING, 32'h1 << POS_FLOW_ASSERTED, "pin fall");
    cts_n <= 1'b1;
    irq_chk(1'b1);
    rd_chk(OFF_INT_PENDING, 32'h1 << POS_FLOW_DEASSERTED, "pin rise");
    $display("test events done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFF_INT_ENABLE_CLEAR, 32'h1 << pos[i]);
      apb(1'b1, OFF_INT_ENABLE_CLEAR, 32'h0);
      exp_en &= ~(32'h1 << pos[i]);
      rd_chk(OFF_INT_ENABLE_CLEAR, exp_en, "clear view");
      rd_chk(OFF_INT_ENABLE_SET, exp_en, "set view");
    end
    @(posedge core_clk);
    ev <= 4'hF;
    @(posedge core_clk);
    ev <= 4'h0;
    irq_chk(1'b0);
    rd_chk(OFF_INT_PENDING, 32'h00020284, "pending masked");
    $display("test clear done");
    // unmapped write refused and leaves the enables alone
    apb(1'b1, 12'h30C, 32'hFFFFFFFF);
    check("unmapped error", {31'h0, err}, 32'h1);
    rd_chk(OFF_INT_ENABLE_SET, 32'h0, "after unmapped");
    $display("test unmapped done");
    // only lane 0 strobed: bits 0, 1, 2 and 7 land, the ones in other lanes do not
    strb <= 4'h1;
    apb(1'b1, OFF_INT_ENABLE_SET, 32'hFFFFFFFF);
    strb <= 4'hF;
    rd_chk(OFF_INT_ENABLE_SET, 32'h00000087, "lane mask");
    $display("test lanes done");
    // reset in mid-run with an enable set and a flag pending
    @(posedge core_clk);
    ev <= 4'h1;
    @(posedge core_clk);
    ev <= 4'h0;
    irq_chk(1'b1);
    rstn <= 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    rd_chk(OFF_INT_ENABLE_CLEAR, 32'h0, "enables after reset");
    rd_chk(OFF_INT_PENDING, 32'h0, "pending after reset");
    irq_chk(1'b0);
    $display("test second reset done");
    finish_test();
  end
endmodule : uie_top_bench
